// ---- core/direct_absolute_addr_gen.sv ----
// operand address generator for absolute and direct modes
`timescale 1ns/1ns
`default_nettype none
module direct_absolute_addr_gen
  import addr_gen_pkg::*;
#(
  parameter int off_w = offset_width,
  parameter int pp_w = periph_page_width
) (
  input wire logic mclk,
  input wire logic rstn,
  // operand request from the decoder
  input wire logic resolve,
  input wire mode_type mode,
  input wire logic paired,
  input wire logic mapped_qualifier,
  input wire logic two_bits,
  input wire logic [data_addr_width-1:0] full_address_constant,
  input wire logic [io_addr_width-1:0] short_constant_operand,
  input wire logic [off_w-1:0] direct_offset,
  // status register one, select bit only is used
  input wire logic [15:0] status_register_one,
  // page pointer and stack pointer loads
  input wire logic load_page_high,
  input wire logic load_page_start,
  input wire logic [page_width-1:0] page_high_in,
  input wire logic [local_width-1:0] page_start_in,
  input wire logic [page_width-1:0] stack_page_high_in,
  input wire logic load_stack_page_high,
  input wire logic [local_width-1:0] stack_pointer_in,
  input wire logic load_stack_pointer,
  input wire logic [pp_w-1:0] periph_page_in,
  input wire logic load_periph_page,
  // results
  output logic addr_valid,
  output space_type access_space,
  output logic [data_addr_width-1:0] data_addr,
  output logic [io_addr_width-1:0] io_addr,
  output logic bit_access,
  output logic [bit_index_width-1:0] bit_index,
  output logic bit_pair,
  output logic pairing_error,
  output logic [data_addr_width-1:0] extended_page_pointer
);
  initial
  begin
    if (off_w != offset_width || pp_w + off_w != io_addr_width)
      $error("offset or peripheral page width unsupported");
  end

  logic [page_width-1:0] main_page_high_reg;
  logic [local_width-1:0] local_page_start_reg;
  logic [page_width-1:0] stack_page_high_reg;
  logic [local_width-1:0] data_stack_pointer_reg;
  logic [pp_w-1:0] peripheral_page_reg;

  logic addr_valid_next;
  space_type access_space_next;
  logic [data_addr_width-1:0] data_addr_next;
  logic [io_addr_width-1:0] io_addr_next;
  logic bit_access_next;
  logic [bit_index_width-1:0] bit_index_next;
  logic bit_pair_next;
  logic pairing_error_next;

  // pointer registers; each part of the extended pointer loads alone or together
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      main_page_high_reg <= page_zero;
      local_page_start_reg <= local_zero;
      stack_page_high_reg <= page_zero;
      data_stack_pointer_reg <= local_zero;
      peripheral_page_reg <= '0;
    end
    else
    begin
      if (load_page_high)
        main_page_high_reg <= page_high_in;
      if (load_page_start)
        local_page_start_reg <= page_start_in;
      if (load_stack_page_high)
        stack_page_high_reg <= stack_page_high_in;
      if (load_stack_pointer)
        data_stack_pointer_reg <= stack_pointer_in;
      if (load_periph_page)
        peripheral_page_reg <= periph_page_in;
    end
  end

  // mode decode
  wire direct_mode_select_bit = status_register_one[status_select_bit];
  wire is_direct = (mode == mode_direct);
  wire use_stack = is_direct && direct_mode_select_bit && !mapped_qualifier;
  wire use_page = is_direct && (!direct_mode_select_bit || mapped_qualifier);

  // mapped qualifier behaves as if both page parts were zero
  wire [page_width-1:0] eff_page_high = mapped_qualifier ? page_zero : main_page_high_reg;
  wire [local_width-1:0] eff_page_start = mapped_qualifier ? local_zero : local_page_start_reg;

  wire [local_width-1:0] page_local;
  wire [local_width-1:0] stack_local;
  wire [io_addr_width-1:0] periph_addr;

  // page direct low half; no alignment on the start value
  page_offset_adder #(.base_width(local_width), .off_width(off_w)) page_sum (
    .base(eff_page_start),
    .offset(direct_offset),
    .sum(page_local)
  );

  // stack direct low half, offset 0 to 127
  page_offset_adder #(.base_width(local_width), .off_width(off_w)) stack_sum (
    .base(data_stack_pointer_reg),
    .offset(direct_offset),
    .sum(stack_local)
  );

  // peripheral page direct, same regardless of select bit
  periph_io_addr #(.pp_width(pp_w), .off_width(off_w)) periph (
    .page(peripheral_page_reg),
    .offset(direct_offset),
    .io_addr(periph_addr)
  );

  // full 23-bit addresses for both direct flavours; page bits on top, local below
  wire [data_addr_width-1:0] page_direct_addr = {eff_page_high, page_local};
  wire [data_addr_width-1:0] stack_direct_addr = {stack_page_high_reg, stack_local};
  // bit offset used as bit number, refused when the access runs past bit 39 of the widest register
  wire bit_in_range = (32'(direct_offset) + (two_bits ? 32'd1 : 32'd0)) <= 32'(max_reg_bit);
  wire [bit_index_width-1:0] bit_from_offset = bit_index_width'(direct_offset);

  // output selection; one result per resolve, registered for the next cycle
  always_comb
  begin
    addr_valid_next = resolve && (mode != mode_none);
    access_space_next = space_none;
    data_addr_next = data_addr;
    io_addr_next = io_addr;
    bit_access_next = 1'b0;
    bit_index_next = bit_index;
    bit_pair_next = 1'b0;
    pairing_error_next = 1'b0;
    if (resolve)
    begin
      case (mode)
        mode_abs23:
        begin
          access_space_next = space_data;
          data_addr_next = full_address_constant;
          pairing_error_next = paired;
        end
        mode_io_abs:
        begin
          access_space_next = space_io;
          io_addr_next = short_constant_operand;
          pairing_error_next = paired;
        end
        mode_direct:
        begin
          access_space_next = space_data;
          if (use_stack)
            data_addr_next = stack_direct_addr;
          else if (use_page)
            data_addr_next = page_direct_addr;
          else
            data_addr_next = data_addr;
        end
        mode_reg_bit:
        begin
          access_space_next = space_none;
          addr_valid_next = bit_in_range;
          bit_access_next = bit_in_range;
          bit_index_next = bit_from_offset;
          bit_pair_next = two_bits && bit_in_range;
        end
        mode_periph:
        begin
          access_space_next = space_io;
          io_addr_next = periph_addr;
        end
        mode_none:
        begin
          access_space_next = space_none;
        end
        default:
        begin
          addr_valid_next = 1'b0;
        end
      endcase
    end
  end

  // result registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_valid <= 1'b0;
      access_space <= space_none;
      data_addr <= data_addr_reset;
      io_addr <= io_addr_reset;
      bit_access <= 1'b0;
      bit_index <= '0;
      bit_pair <= 1'b0;
      pairing_error <= 1'b0;
      extended_page_pointer <= data_addr_reset;
    end
    else
    begin
      addr_valid <= addr_valid_next;
      access_space <= access_space_next;
      data_addr <= data_addr_next;
      io_addr <= io_addr_next;
      bit_access <= bit_access_next;
      bit_index <= bit_index_next;
      bit_pair <= bit_pair_next;
      pairing_error <= pairing_error_next;
      extended_page_pointer <= {main_page_high_reg, local_page_start_reg};
    end
  end

  // checks
  a_abs23_passthru: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_abs23 |=> data_addr == $past(full_address_constant) && access_space == space_data)
    else $error("23-bit constant not driven unchanged");

  a_io_abs_addr: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_io_abs |=> io_addr == $past(short_constant_operand) && access_space == space_io)
    else $error("i/o absolute address wrong");

  a_io_abs_pair: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_io_abs && paired |=> pairing_error)
    else $error("paired extension instruction not flagged");

  a_page_direct: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_direct && !status_register_one[status_select_bit] && !mapped_qualifier
    |=> data_addr == {$past(main_page_high_reg), 16'($past(local_page_start_reg) + 16'($past(direct_offset)))})
    else $error("page direct address wrong");

  a_stack_direct: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_direct && status_register_one[status_select_bit] && !mapped_qualifier
    |=> data_addr[15:0] == 16'($past(data_stack_pointer_reg) + 16'($past(direct_offset)))
    && data_addr[22:16] == $past(stack_page_high_reg))
    else $error("stack direct address wrong");

  a_mapped_zero: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_direct && mapped_qualifier |=> data_addr == 23'($past(direct_offset)))
    else $error("mapped qualifier did not force page zero");

  a_periph_addr: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_periph |=> io_addr == {$past(peripheral_page_reg), $past(direct_offset)}
    && access_space == space_io)
    else $error("peripheral page address wrong");

  a_bit_index: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_reg_bit && !two_bits && direct_offset <= off_w'(max_reg_bit)
    |=> bit_access && bit_index == bit_index_width'($past(direct_offset)))
    else $error("bit offset not used as bit number");

  a_ext_ptr_load: assert property (@(posedge mclk) disable iff (!rstn)
    load_page_high && load_page_start ##1 !load_page_high && !load_page_start
    |=> extended_page_pointer == {$past(page_high_in, 2), $past(page_start_in, 2)})
    else $error("extended page pointer load wrong");

  a_aux_zero_map: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_direct && mapped_qualifier && direct_offset == off_w'(aux_register_zero_addr)
    |=> data_addr == aux_register_zero_addr)
    else $error("mapped aux register zero address wrong");

  a_direct_space: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_direct |=> addr_valid && access_space == space_data)
    else $error("direct address not presented with data space");

  a_bit_pair: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_reg_bit && two_bits && direct_offset < off_w'(max_reg_bit)
    |=> bit_access && bit_pair)
    else $error("two-bit access not flagged");

  a_bit_refused: assert property (@(posedge mclk) disable iff (!rstn)
    resolve && mode == mode_reg_bit && direct_offset > off_w'(max_reg_bit) |=> !addr_valid && !bit_access)
    else $error("out-of-range bit access not refused");
endmodule : direct_absolute_addr_gen
`default_nettype wire

// ---- core/addr_gen_pkg.sv ----
// constants and types shared by the direct and absolute address generator
package addr_gen_pkg;
  localparam int data_addr_width = 23;
  localparam int local_width = 16;
  localparam int page_width = 7;
  localparam int offset_width = 7;
  localparam int io_addr_width = 16;
  localparam int periph_page_width = 9;
  localparam int bit_index_width = 6;
  localparam int max_reg_bit = 39;
  localparam int status_select_bit = 14;
  localparam logic [page_width-1:0] page_zero = 7'h00;
  localparam logic [local_width-1:0] local_zero = 16'h0000;
  localparam logic [data_addr_width-1:0] data_addr_reset = 23'h000000;
  localparam logic [io_addr_width-1:0] io_addr_reset = 16'h0000;
  localparam logic [data_addr_width-1:0] aux_register_zero_addr = 23'h000010;

  // one-hot operand modes from the decoder
  typedef enum logic [5:0] {
    mode_none = 6'b000001,
    mode_abs23 = 6'b000010,
    mode_io_abs = 6'b000100,
    mode_direct = 6'b001000,
    mode_reg_bit = 6'b010000,
    mode_periph = 6'b100000
  } mode_type;

  // one-hot access space indication
  typedef enum logic [2:0] {
    space_none = 3'b001,
    space_data = 3'b010,
    space_io = 3'b100
  } space_type;
endpackage : addr_gen_pkg

// ---- core/page_offset_adder.sv ----
// page-relative adder: base plus 7-bit offset, carry dropped
`timescale 1ns/1ns
`default_nettype none
module page_offset_adder
  import addr_gen_pkg::*;
#(
  parameter int base_width = 16,
  parameter int off_width = 7
) (
  input wire logic [base_width-1:0] base,
  input wire logic [off_width-1:0] offset,
  output logic [base_width-1:0] sum
);
  initial
  begin
    if (off_width > base_width)
      $error("offset wider than base");
  end

  // wraps inside the page, no carry into the page bits
  assign sum = base + base_width'(offset);
endmodule : page_offset_adder
`default_nettype wire

// ---- core/periph_io_addr.sv ----
// peripheral page plus offset into a 16-bit i/o address
`timescale 1ns/1ns
`default_nettype none
module periph_io_addr
  import addr_gen_pkg::*;
#(
  parameter int pp_width = 9,
  parameter int off_width = 7
) (
  input wire logic [pp_width-1:0] page,
  input wire logic [off_width-1:0] offset,
  output logic [pp_width+off_width-1:0] io_addr
);
  // 512 pages of 128 words, page bits on top
  assign io_addr = {page, offset};
endmodule : periph_io_addr
`default_nettype wire

// ---- dv/mem_space_model.sv ----
// memory and i/o space sink that counts the accesses it accepts
`timescale 1ns/1ns
`default_nettype none
module mem_space_model
  import addr_gen_pkg::*;
(
  input wire logic mclk,
  input wire logic addr_valid,
  input wire space_type access_space,
  output logic [15:0] data_hits,
  output logic [15:0] io_hits
);
  initial data_hits = 16'h0000;
  initial io_hits = 16'h0000;
  // space is only trusted in the valid cycle, later it may be stale
  always @(posedge mclk)
  begin
    if (addr_valid === 1'b1 && access_space === space_data)
      data_hits <= data_hits + 16'h0001;
    if (addr_valid === 1'b1 && access_space === space_io)
      io_hits <= io_hits + 16'h0001;
  end
endmodule : mem_space_model
`default_nettype wire

// ---- dv/tb_direct_absolute_addr_gen.sv ----
// self-checking bench for the direct and absolute address generator
`timescale 1ns/1ns
`default_nettype none
module tb_direct_absolute_addr_gen
  import addr_gen_pkg::*;
;
  typedef struct {mode_type md; space_type spc; logic [22:0] da; logic [15:0] ia; logic [5:0] bi; logic bp; logic pe;} note_type;
  note_type notes[$];
  note_type mn;
  logic mclk, rstn = 0, resolve = 0, paired = 0, mq = 0, two_bits = 0;
  mode_type mode = mode_none;
  logic [22:0] abs_const = 0, data_addr, ext_ptr;
  logic [15:0] io_const = 0, sr1 = 0, ps_in = 0, stk_in = 0, io_addr, data_hits, io_hits, exp_d = 0, exp_i = 0;
  logic [6:0] off = 0, ph_in = 0, stk_hi_in = 0, ph = 0, stk_hi = 0;
  logic [15:0] ps = 0, stk_ptr = 0;
  logic [8:0] pp_in = 0, pp = 0;
  logic [4:0] ld = 0;
  logic addr_valid, bit_access, bit_pair, pairing_error;
  space_type access_space;
  logic [5:0] bit_index;
  int fails = 0, checked = 0;

  direct_absolute_addr_gen dut_u (.mclk(mclk), .rstn(rstn), .resolve(resolve), .mode(mode), .paired(paired),
    .mapped_qualifier(mq), .two_bits(two_bits), .full_address_constant(abs_const), .short_constant_operand(io_const),
    .direct_offset(off), .status_register_one(sr1), .load_page_high(ld[0]), .load_page_start(ld[1]),
    .page_high_in(ph_in), .page_start_in(ps_in), .stack_page_high_in(stk_hi_in), .load_stack_page_high(ld[2]),
    .stack_pointer_in(stk_in), .load_stack_pointer(ld[3]), .periph_page_in(pp_in), .load_periph_page(ld[4]),
    .addr_valid(addr_valid), .access_space(access_space), .data_addr(data_addr), .io_addr(io_addr),
    .bit_access(bit_access), .bit_index(bit_index), .bit_pair(bit_pair), .pairing_error(pairing_error),
    .extended_page_pointer(ext_ptr));
  mem_space_model mem_u (.mclk(mclk), .addr_valid(addr_valid), .access_space(access_space),
    .data_hits(data_hits), .io_hits(io_hits));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // pointer loads, mirrored here; the extended pointer is checked after it settles
  task automatic load(input logic [4:0] en, input logic [6:0] a, input logic [15:0] b, input logic [8:0] c);
    @(negedge mclk);
    resolve = 1'b0;
    ld = en;
    ph_in = a;
    stk_hi_in = a;
    ps_in = b;
    stk_in = b;
    pp_in = c;
    ph = en[0] ? a : ph;
    ps = en[1] ? b : ps;
    stk_hi = en[2] ? a : stk_hi;
    stk_ptr = en[3] ? b : stk_ptr;
    pp = en[4] ? c : pp;
    @(negedge mclk);
    ld = 5'h00;
    @(negedge mclk);
    check(ext_ptr, {ph, ps});
  endtask : load

  // one operand request; the expected outcome is queued for the monitor
  task automatic req(input mode_type m, input logic [22:0] k, input logic [6:0] o, input logic sel,
                     input logic q, input logic tb, input logic pr);
    note_type n;
    logic quiet;
    @(negedge mclk);
    mode = m;
    abs_const = k;
    io_const = k[15:0];
    off = o;
    sr1 = {1'b0, sel, 14'h0000};
    mq = q;
    two_bits = tb;
    paired = pr;
    resolve = 1'b1;
    n.md = m;
    n.spc = (m == mode_io_abs || m == mode_periph) ? space_io : (m == mode_reg_bit) ? space_none : space_data;
    n.da = (m == mode_abs23) ? k : q ? {16'h0000, o} : sel ? {stk_hi, stk_ptr + 16'(o)} : {ph, ps + 16'(o)};
    n.ia = (m == mode_io_abs) ? k[15:0] : {pp, o};
    n.bi = o[5:0];
    n.bp = tb;
    n.pe = pr && (m == mode_abs23 || m == mode_io_abs);
    // no-operand and out-of-range bit requests must stay silent, so nothing is queued
    quiet = (m == mode_none) || (m == mode_reg_bit && int'(o) + int'(tb) > max_reg_bit);
    if (!quiet)
      notes.push_back(n);
    if (!quiet && n.spc == space_data)
      exp_d++;
    if (!quiet && n.spc == space_io)
      exp_i++;
  endtask : req

  // monitor samples just after each edge so the edge's updates have landed
  always @(posedge mclk)
  begin
    #1;
    if (addr_valid === 1'b1 || pairing_error === 1'b1)
    begin
      if (notes.size() == 0)
        check(23'h1, 23'h0);
      else
      begin
        mn = notes.pop_front();
        check(addr_valid, 1'b1);
        check(pairing_error, mn.pe);
        if (mn.md == mode_reg_bit)
        begin
          check({bit_access, bit_pair, bit_index}, {1'b1, mn.bp, mn.bi});
          check(access_space, mn.spc);
        end
        else
        begin
          check(access_space, mn.spc);
          if (mn.spc == space_data)
            check(data_addr, mn.da);
          else
            check(io_addr, mn.ia);
        end
      end
    end
  end

  // hang guard
  initial
  begin
    repeat (5000) @(posedge mclk);
    fails++;
    test_done();
  end

  initial
  begin
    void'($urandom(88));
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    check(access_space, space_none);
    check(ext_ptr, 23'h0);
    for (int i = 0; i < 12; i++)
      req(i[0] ? mode_abs23 : mode_io_abs, 23'($urandom), 7'h00, 1'b0, 1'b0, 1'b0, i[1]);
    // a request without an operand must produce no access at all
    req(mode_none, 23'h7fffff, 7'h7f, 1'b0, 1'b0, 1'b0, 1'b1);
    $display("test absolute done");
    load(5'h03, 7'h03, 16'hfff0, 9'h000);
    req(mode_direct, 0, 7'(16'hfff4 - 16'hfff0), 1'b0, 1'b0, 1'b0, 1'b0);
    req(mode_direct, 0, 7'h7f, 1'b0, 1'b0, 1'b0, 1'b0);
    req(mode_direct, 0, 7'(aux_register_zero_addr), 1'b0, 1'b1, 1'b0, 1'b0);
    req(mode_direct, 0, 7'(aux_register_zero_addr), 1'b1, 1'b1, 1'b0, 1'b0);
    load(5'h01, 7'h7f, 16'h0000, 9'h000);
    load(5'h02, 7'h00, 16'($urandom), 9'h000);
    for (int i = 0; i < 8; i++)
      req(mode_direct, 0, 7'($urandom), 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test page direct done");
    load(5'h0c, 7'($urandom), 16'($urandom), 9'h000);
    for (int i = 0; i < 8; i++)
      req(mode_direct, 0, 7'($urandom), 1'b1, 1'b0, 1'b0, 1'b0);
    $display("test stack direct done");
    for (int o = 0; o < 42; o++)
      req(mode_reg_bit, 0, 7'(o), 1'($urandom), 1'b0, (o >= 38) ? o[0] : 1'($urandom), 1'b0);
    $display("test register bit done");
    load(5'h10, 7'h00, 16'h0000, 9'($urandom));
    for (int i = 0; i < 8; i++)
      req(mode_periph, 0, 7'($urandom), 1'($urandom), 1'b0, 1'b0, 1'b0);
    $display("test peripheral done");
    @(negedge mclk);
    resolve = 1'b0;
    repeat (3) @(negedge mclk);
    check(data_hits, exp_d);
    check(io_hits, exp_i);
    check(23'(notes.size()), 23'h0);
    test_done();
  end
endmodule : tb_direct_absolute_addr_gen
`default_nettype wire
